// [common/bst_params.svh]
// constants of the boundary-scan test port
`ifndef BST_PARAMS_SVH
`define BST_PARAMS_SVH
`define BST_N_IO        96
`define BST_N_IN        4
`define BST_N_MC        16
`define BST_IO_CAP      3
`define BST_IO_UPD      2
`define BST_IN_CAP      1
`define BST_IN_UPD      1
`define BST_MC_CAP      1
`define BST_MC_UPD      0
`define BST_IR_W        4
`define BST_IR_CAPTURE  4'h1
`define BST_OP_EXTEST   4'h0
`define BST_OP_SAMPLE   4'h1
`define BST_OP_IDCODE   4'h2
`define BST_OP_PROG     4'h8
`define BST_OP_BYPASS   4'hf
// identification value is arbitrary
`define BST_IDCODE      32'h0abc_d001
`define BST_PROG_W      32
`define BST_ADR_CTRL    2'h0
`define BST_ADR_STATUS  2'h1
`define BST_ADR_ID      2'h2
`define BST_ADR_PROG    2'h3
`define BST_CTRL_RST    3'h7
`define BST_CTRL_EN     0
`define BST_CTRL_TMS_PU 1
`define BST_CTRL_TDI_PU 2
`define BST_PIN_TCK     0
`define BST_PIN_TMS     1
`define BST_PIN_TDI     2
`define BST_PIN_TDO     3
`endif

// [common/bst_pkg.sv]
// types of the boundary-scan test port
package bst_pkg;
	typedef enum logic [3:0] {
		ST_TLR, ST_RTI, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PA_DR, ST_EX2_DR,
		ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PA_IR, ST_EX2_IR, ST_UPD_IR
	} bst_tap_state_t;

	typedef struct packed {
		logic capture;
		logic shift;
		logic update;
	} bst_cell_ctl_t;

	function automatic logic bst_is_shift(input bst_tap_state_t s);
		return (s == ST_SH_DR) || (s == ST_SH_IR);
	endfunction
endpackage

// [hw/bst_scan_cell.sv]
// one scan cell: capture/shift bits and optional update bits
`timescale 1ns/1ns
`default_nettype none
module bst_scan_cell #(
	parameter int CAP = 3,
	parameter int UPD = 2
) (
	input  wire logic                             clk_i,
	input  wire logic                             rst_i,
	input  wire bst_pkg::bst_cell_ctl_t           ctl_i,
	input  wire logic [CAP-1:0]                   cap_i,
	input  wire logic                             si_i,
	output logic                                  so_o,
	output logic [((UPD > 0) ? UPD : 1)-1:0]      upd_o
);
	logic [CAP-1:0] cap_q;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			cap_q <= '0;
		else if (ctl_i.capture)
			cap_q <= cap_i;
		else if (ctl_i.shift)
			cap_q <= (cap_q >> 1) | (CAP'(si_i) << (CAP - 1));
	end

	assign so_o = cap_q[0];

	generate
		if (UPD > 0)
		begin : g_upd
			logic [UPD-1:0] upd_q;
			always_ff @(posedge clk_i)
			begin
				if (rst_i)
					upd_q <= '0;
				else if (ctl_i.update)
					upd_q <= cap_q[UPD-1:0];
			end
			assign upd_o = upd_q;
		end
		else
		begin : g_noupd
			// observe-only cell: nothing to drive
			assign upd_o = '0;
		end
	endgenerate
endmodule // bst_scan_cell
`default_nettype wire

// [hw/bst_tap_fsm.sv]
// sixteen-state TAP controller
`timescale 1ns/1ns
`default_nettype none
module bst_tap_fsm (
	input  wire logic            clk_i,
	input  wire logic            rst_i,
	input  wire logic            hold_i,
	input  wire logic            step_i,
	input  wire logic            tms_i,
	output bst_pkg::bst_tap_state_t state_o
);
	function automatic bst_pkg::bst_tap_state_t nxt(input bst_pkg::bst_tap_state_t s,
	                                                input logic m);
		unique case (s)
			bst_pkg::ST_TLR:    return m ? bst_pkg::ST_TLR    : bst_pkg::ST_RTI;
			bst_pkg::ST_RTI:    return m ? bst_pkg::ST_SEL_DR : bst_pkg::ST_RTI;
			bst_pkg::ST_SEL_DR: return m ? bst_pkg::ST_SEL_IR : bst_pkg::ST_CAP_DR;
			bst_pkg::ST_CAP_DR: return m ? bst_pkg::ST_EX1_DR : bst_pkg::ST_SH_DR;
			bst_pkg::ST_SH_DR:  return m ? bst_pkg::ST_EX1_DR : bst_pkg::ST_SH_DR;
			bst_pkg::ST_EX1_DR: return m ? bst_pkg::ST_UPD_DR : bst_pkg::ST_PA_DR;
			bst_pkg::ST_PA_DR:  return m ? bst_pkg::ST_EX2_DR : bst_pkg::ST_PA_DR;
			bst_pkg::ST_EX2_DR: return m ? bst_pkg::ST_UPD_DR : bst_pkg::ST_SH_DR;
			bst_pkg::ST_UPD_DR: return m ? bst_pkg::ST_SEL_DR : bst_pkg::ST_RTI;
			bst_pkg::ST_SEL_IR: return m ? bst_pkg::ST_TLR    : bst_pkg::ST_CAP_IR;
			bst_pkg::ST_CAP_IR: return m ? bst_pkg::ST_EX1_IR : bst_pkg::ST_SH_IR;
			bst_pkg::ST_SH_IR:  return m ? bst_pkg::ST_EX1_IR : bst_pkg::ST_SH_IR;
			bst_pkg::ST_EX1_IR: return m ? bst_pkg::ST_UPD_IR : bst_pkg::ST_PA_IR;
			bst_pkg::ST_PA_IR:  return m ? bst_pkg::ST_EX2_IR : bst_pkg::ST_PA_IR;
			bst_pkg::ST_EX2_IR: return m ? bst_pkg::ST_UPD_IR : bst_pkg::ST_SH_IR;
			bst_pkg::ST_UPD_IR: return m ? bst_pkg::ST_SEL_DR : bst_pkg::ST_RTI;
		endcase
	endfunction

	always_ff @(posedge clk_i)
	begin
		if (rst_i || hold_i)
			state_o <= bst_pkg::ST_TLR;
		else if (step_i)
			state_o <= nxt(state_o, tms_i);
	end
endmodule // bst_tap_fsm
`default_nettype wire

// [hw/bst_test_port.sv]
// boundary-scan test port: TAP, scan chain, programming register, Wishbone config
//
// The register offsets and the Wishbone slave port were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "bst_params.svh"
module bst_test_port (
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	input  wire logic                  wb_cyc_i,
	input  wire logic                  wb_stb_i,
	input  wire logic                  wb_we_i,
	input  wire logic [3:0]            wb_adr_i,
	input  wire logic [3:0]            wb_sel_i,
	input  wire logic [31:0]           wb_dat_i,
	output logic      [31:0]           wb_dat_o,
	output logic                       wb_ack_o,
	input  wire logic [3:0]            jpin_i,
	output logic      [3:0]            jpin_o,
	output logic      [3:0]            jpin_oe_o,
	output logic      [3:0]            user_jpin_o,
	input  wire logic [3:0]            user_jpin_i,
	input  wire logic [3:0]            user_jpin_oe_i,
	output logic      [1:0]            pull_o,
	input  wire logic [`BST_N_IO-1:0]  io_pin_i,
	output logic      [`BST_N_IO-1:0]  io_pin_o,
	output logic      [`BST_N_IO-1:0]  io_pin_oe_o,
	output logic      [`BST_N_IO-1:0]  core_io_o,
	input  wire logic [`BST_N_IO-1:0]  core_io_i,
	input  wire logic [`BST_N_IO-1:0]  core_io_oe_i,
	input  wire logic [`BST_N_IN-1:0]  in_pin_i,
	output logic      [`BST_N_IN-1:0]  core_in_o,
	input  wire logic [`BST_N_MC-1:0]  mc_i,
	output logic      [`BST_PROG_W-1:0] prog_data_o,
	output logic                       prog_stb_o
);
	localparam int NCELL = `BST_N_IO + `BST_N_IN + `BST_N_MC;

	logic [3:0]                jp_s1_q, jp_s2_q;
	logic                      tck_s3_q;
	logic [`BST_N_IO-1:0]      io_s1_q, io_s2_q;
	logic [`BST_N_IN-1:0]      in_s1_q, in_s2_q;
	logic [2:0]                ctrl_q;
	logic [`BST_IR_W-1:0]      ir_q, ir_sh_q;
	logic [31:0]               id_sh_q;
	logic [`BST_PROG_W-1:0]    prog_sh_q;
	logic                      bypass_q;
	logic                      tck_rise, tck_fall, tms_s, tdi_s, jtag_en;
	logic                      chain_sel, extest, dr_out;
	bst_pkg::bst_tap_state_t   st;
	bst_pkg::bst_cell_ctl_t    cell_ctl;
	logic [NCELL:0]            link;
	logic [`BST_N_IO-1:0]      io_upd_out, io_upd_oe;
	logic [`BST_N_IN-1:0]      in_upd;
	logic                      wb_req;

	// second flop feeds the edge detector so the first flop stays private
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			jp_s1_q  <= 4'h0;
			jp_s2_q  <= 4'h0;
			tck_s3_q <= 1'b0;
			io_s1_q  <= '0;
			io_s2_q  <= '0;
			in_s1_q  <= '0;
			in_s2_q  <= '0;
		end
		else
		begin
			jp_s1_q  <= jpin_i;
			jp_s2_q  <= jp_s1_q;
			tck_s3_q <= jp_s2_q[`BST_PIN_TCK];
			io_s1_q  <= io_pin_i;
			io_s2_q  <= io_s1_q;
			in_s1_q  <= in_pin_i;
			in_s2_q  <= in_s1_q;
		end
	end

	assign jtag_en  = ctrl_q[`BST_CTRL_EN];
	assign tms_s    = jp_s2_q[`BST_PIN_TMS];
	assign tdi_s    = jp_s2_q[`BST_PIN_TDI];
	// test clock must stay well below clk_i/4 for edges to be seen
	assign tck_rise = jtag_en & jp_s2_q[`BST_PIN_TCK] & ~tck_s3_q;
	assign tck_fall = jtag_en & ~jp_s2_q[`BST_PIN_TCK] & tck_s3_q;

	bst_tap_fsm u_fsm (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.hold_i  (~jtag_en),
		.step_i  (tck_rise),
		.tms_i   (tms_s),
		.state_o (st)
	);

	function automatic logic is_chain(input logic [`BST_IR_W-1:0] op);
		return (op == `BST_OP_EXTEST) || (op == `BST_OP_SAMPLE);
	endfunction

	assign chain_sel = is_chain(ir_q);
	assign extest    = jtag_en && (ir_q == `BST_OP_EXTEST);

	// cell strobes come only from the controller state, a chain instruction and test-clock edges
	always_comb
	begin
		cell_ctl.capture = tck_rise && chain_sel && (st == bst_pkg::ST_CAP_DR);
		cell_ctl.shift   = tck_rise && chain_sel && (st == bst_pkg::ST_SH_DR);
		cell_ctl.update  = tck_fall && chain_sel && (st == bst_pkg::ST_UPD_DR);
	end

	assign link[NCELL] = tdi_s;

	genvar k;
	generate
		for (k = 0; k < `BST_N_IO; k++)
		begin : g_io
			bst_scan_cell #(.CAP(`BST_IO_CAP), .UPD(`BST_IO_UPD)) u_cell (
				.clk_i (clk_i),
				.rst_i (rst_i),
				.ctl_i (cell_ctl),
				.cap_i ({io_s2_q[k], core_io_oe_i[k], core_io_i[k]}),
				.si_i  (link[k+1]),
				.so_o  (link[k]),
				.upd_o ({io_upd_oe[k], io_upd_out[k]})
			);
		end
		for (k = 0; k < `BST_N_IN; k++)
		begin : g_in
			bst_scan_cell #(.CAP(`BST_IN_CAP), .UPD(`BST_IN_UPD)) u_cell (
				.clk_i (clk_i),
				.rst_i (rst_i),
				.ctl_i (cell_ctl),
				.cap_i (in_s2_q[k]),
				.si_i  (link[`BST_N_IO+k+1]),
				.so_o  (link[`BST_N_IO+k]),
				.upd_o (in_upd[k])
			);
		end
		for (k = 0; k < `BST_N_MC; k++)
		begin : g_mc
			bst_scan_cell #(.CAP(`BST_MC_CAP), .UPD(`BST_MC_UPD)) u_cell (
				.clk_i (clk_i),
				.rst_i (rst_i),
				.ctl_i (cell_ctl),
				.cap_i (mc_i[k]),
				.si_i  (link[`BST_N_IO+`BST_N_IN+k+1]),
				.so_o  (link[`BST_N_IO+`BST_N_IN+k]),
				.upd_o ()
			);
		end
	endgenerate

	// instruction register; unknown codes fall back to bypass
	always_ff @(posedge clk_i)
	begin
		if (rst_i || st == bst_pkg::ST_TLR)
		begin
			ir_q    <= `BST_OP_IDCODE;
			ir_sh_q <= `BST_IR_CAPTURE;
		end
		else if (tck_rise && st == bst_pkg::ST_CAP_IR)
			ir_sh_q <= `BST_IR_CAPTURE;
		else if (tck_rise && st == bst_pkg::ST_SH_IR)
			ir_sh_q <= {tdi_s, ir_sh_q[`BST_IR_W-1:1]};
		else if (tck_fall && st == bst_pkg::ST_UPD_IR)
			ir_q <= ir_sh_q;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			bypass_q <= 1'b0;
			id_sh_q  <= 32'h0;
		end
		else if (tck_rise && st == bst_pkg::ST_CAP_DR)
		begin
			bypass_q <= 1'b0;
			id_sh_q  <= `BST_IDCODE;
		end
		else if (tck_rise && st == bst_pkg::ST_SH_DR)
		begin
			bypass_q <= tdi_s;
			id_sh_q  <= {tdi_s, id_sh_q[31:1]};
		end
	end

	// programming word register: shifted in, delivered with a one-cycle strobe
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			prog_sh_q   <= '0;
			prog_data_o <= '0;
			prog_stb_o  <= 1'b0;
		end
		else
		begin
			prog_stb_o <= 1'b0;
			if (ir_q == `BST_OP_PROG)
			begin
				if (tck_rise && st == bst_pkg::ST_CAP_DR)
					prog_sh_q <= prog_data_o;
				else if (tck_rise && st == bst_pkg::ST_SH_DR)
					prog_sh_q <= {tdi_s, prog_sh_q[`BST_PROG_W-1:1]};
				else if (tck_fall && st == bst_pkg::ST_UPD_DR)
				begin
					prog_data_o <= prog_sh_q;
					prog_stb_o  <= 1'b1;
				end
			end
		end
	end

	always_comb
	begin
		if (chain_sel)
			dr_out = link[0];
		else if (ir_q == `BST_OP_IDCODE)
			dr_out = id_sh_q[0];
		else if (ir_q == `BST_OP_PROG)
			dr_out = prog_sh_q[0];
		else
			dr_out = bypass_q;
	end

	// with the port enabled, data-out and its enable change on the falling test-clock edge, the enable set only in a shift state
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			jpin_o      <= 4'h0;
			jpin_oe_o   <= 4'h0;
			user_jpin_o <= 4'h0;
		end
		else if (!jtag_en)
		begin
			jpin_o      <= user_jpin_i;
			jpin_oe_o   <= user_jpin_oe_i;
			user_jpin_o <= jp_s2_q;
		end
		else
		begin
			user_jpin_o  <= 4'h0;
			jpin_o[2:0]    <= 3'h0;
			jpin_oe_o[2:0] <= 3'h0;
			if (tck_fall)
			begin
				jpin_o[`BST_PIN_TDO]    <= (st == bst_pkg::ST_SH_IR) ? ir_sh_q[0] : dr_out;
				jpin_oe_o[`BST_PIN_TDO] <= bst_pkg::bst_is_shift(st);
			end
		end
	end

	// pad and core sides are re-timed: pads cost one clk_i of latency, core side three with the synchroniser
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			io_pin_o    <= '0;
			io_pin_oe_o <= '0;
			core_io_o   <= '0;
			core_in_o   <= '0;
		end
		else
		begin
			io_pin_o    <= extest ? io_upd_out : core_io_i;
			io_pin_oe_o <= extest ? io_upd_oe : core_io_oe_i;
			core_io_o   <= io_s2_q;
			core_in_o   <= extest ? in_upd : in_s2_q;
		end
	end

	assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
			ctrl_q   <= `BST_CTRL_RST;
			pull_o   <= 2'h0;
		end
		else
		begin
			wb_ack_o <= wb_req;
			pull_o   <= {ctrl_q[`BST_CTRL_TDI_PU], ctrl_q[`BST_CTRL_TMS_PU]};
			if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i[3:2] == `BST_ADR_CTRL)
				ctrl_q <= wb_dat_i[2:0];
			if (wb_req)
			begin
				unique case (wb_adr_i[3:2])
					`BST_ADR_CTRL:   wb_dat_o <= {29'h0, ctrl_q};
					`BST_ADR_STATUS: wb_dat_o <= {24'h0, ir_q, st};
					`BST_ADR_ID:     wb_dat_o <= `BST_IDCODE;
					`BST_ADR_PROG:   wb_dat_o <= prog_data_o;
				endcase
			end
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	tlr_after_reset_a: assert property ($fell(rst_i) |-> st == bst_pkg::ST_TLR
		&& ir_q == `BST_OP_IDCODE) else $error("tap not in reset after reset");
	ir_capture_a: assert property (tck_rise && st == bst_pkg::ST_CAP_IR
		|=> ir_sh_q == `BST_IR_CAPTURE) else $error("ir capture value wrong");
	id_capture_a: assert property (tck_rise && st == bst_pkg::ST_CAP_DR
		|=> id_sh_q == `BST_IDCODE) else $error("id capture value wrong");
	bypass_bit_a: assert property (tck_rise && st == bst_pkg::ST_SH_DR
		|=> bypass_q == $past(tdi_s)) else $error("bypass bit did not take data-in");
	extest_drive_a: assert property (extest && $stable(io_upd_out)
		|=> io_pin_o == $past(io_upd_out)) else $error("pads not driven from update bits");
	tdo_enable_a: assert property (tck_fall && !bst_pkg::bst_is_shift(st)
		|=> !jpin_oe_o[`BST_PIN_TDO] [*1] ##1 !jpin_oe_o[`BST_PIN_TDO])
		else $error("data-out driven outside shift");
	user_mode_a: assert property (!jtag_en ##1 !jtag_en
		|-> st == bst_pkg::ST_TLR && user_jpin_o == $past(jp_s2_q))
		else $error("disabled port not passing user pins");
	pullup_cfg_a: assert property ($changed(ctrl_q) |=> pull_o
		== {$past(ctrl_q[`BST_CTRL_TDI_PU]), $past(ctrl_q[`BST_CTRL_TMS_PU])})
		else $error("pull-up select not following config");
	prog_strobe_a: assert property (tck_fall && st == bst_pkg::ST_UPD_DR
		&& ir_q == `BST_OP_PROG |=> prog_stb_o ##1 !prog_stb_o)
		else $error("programming strobe wrong");
	ctl_source_a: assert property (cell_ctl.shift |-> tck_rise
		##1 link[NCELL-1] == $past(tdi_s)) else $error("chain did not take data-in on shift");
endmodule // bst_test_port
`default_nettype wire

// [test/bst_jtag_tester.sv]
// behavioural test-clock master that drives the scan port pins
`timescale 1ns/1ns
`default_nettype none
module bst_jtag_tester (
	input  wire logic clk_i,
	input  wire logic tdo_i,
	output logic      tck_o,
	output logic      tms_o,
	output logic      tdi_o
);
	initial
	begin
		tck_o = 1'b0;
		tms_o = 1'b1;
		tdi_o = 1'b1;
	end

	// mode and data change with the test clock low; data-out is read late in the high half
	task automatic tick(input logic m, input logic d, output logic q);
		@(posedge clk_i);
		tck_o <= 1'b0;
		tms_o <= m;
		tdi_o <= d;
		repeat (4) @(posedge clk_i);
		tck_o <= 1'b1;
		repeat (3) @(posedge clk_i);
		@(negedge clk_i);
		q = tdo_i;
	endtask

	task automatic to_idle();
		logic q;
		repeat (5) tick(1'b1, 1'b0, q);
		tick(1'b0, 1'b0, q);
	endtask

	// from idle: walk to a shift state, move n bits lsb first, update, back to idle
	task automatic scan(input logic ir, input int n, input logic [307:0] din,
		output logic [307:0] dout);
		logic q;
		dout = '0;
		tick(1'b1, 1'b0, q);
		if (ir)
			tick(1'b1, 1'b0, q);
		tick(1'b0, 1'b0, q);
		tick(1'b0, 1'b0, q);
		for (int i = 0; i < n; i++)
		begin
			tick(i == n - 1, din[i], q);
			dout[i] = q;
		end
		tick(1'b1, 1'b0, q);
		tick(1'b0, 1'b0, q);
	endtask
endmodule // bst_jtag_tester
`default_nettype wire

// [test/bst_test_port_tb.sv]
// self-checking bench of the boundary-scan test port
`timescale 1ns/1ns
`default_nettype none
`include "bst_params.svh"
module bst_test_port_tb;
	logic                 clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic                 prog_stb_o, flt, tck, tms, tdi;
	logic [3:0]           wb_adr_i, wb_sel_i, jpin_w, jpin_o, jpin_oe_o, in_pin_i, core_in_o;
	logic [3:0]           user_jpin_o, user_jpin_i, user_jpin_oe_i;
	logic [31:0]          wb_dat_i, wb_dat_o, prog_data_o;
	logic [1:0]           pull_o;
	logic [`BST_N_IO-1:0] io_pin_i, io_pin_o, io_pin_oe_o, core_io_o, core_io_i, core_io_oe_i;
	logic [15:0]          mc_i;
	int                   errors, total_checks, stb_n;

	// an undriven data-out pin wanders so that a stale level is never read as valid
	assign jpin_w = (jpin_oe_o & jpin_o) | (~jpin_oe_o & {flt, tdi, tms, tck});

	bst_test_port bst_test_port_inst (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .jpin_i(jpin_w), .jpin_o(jpin_o),
		.jpin_oe_o(jpin_oe_o), .user_jpin_o(user_jpin_o), .user_jpin_i(user_jpin_i),
		.user_jpin_oe_i(user_jpin_oe_i), .pull_o(pull_o), .io_pin_i(io_pin_i),
		.io_pin_o(io_pin_o), .io_pin_oe_o(io_pin_oe_o), .core_io_o(core_io_o),
		.core_io_i(core_io_i), .core_io_oe_i(core_io_oe_i), .in_pin_i(in_pin_i),
		.core_in_o(core_in_o), .mc_i(mc_i), .prog_data_o(prog_data_o),
		.prog_stb_o(prog_stb_o)
	);

	bst_jtag_tester bst_jtag_tester_inst (
		.clk_i(clk_i), .tdo_i(jpin_w[3]), .tck_o(tck), .tms_o(tms), .tdi_o(tdi)
	);

	initial
	begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	always @(posedge clk_i)
	begin
		flt <= ~flt;
		if (prog_stb_o === 1'b1)
			stb_n++;
	end

	task automatic tally_and_finish();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [307:0] e, input logic [307:0] g);
		total_checks++;
		if (g !== e)
		begin
			errors++;
			$display("[ERR] %s expected %0h seen %0h", nm, e, g);
		end
	endtask

	task automatic wb(input logic we, input logic [3:0] adr, input logic [3:0] sel,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= adr;
		wb_sel_i <= sel;
		wb_dat_i <= d;
		do
			@(posedge clk_i);
		while (wb_ack_o !== 1'b1 && ++n < 20);
		q = wb_dat_o;
		if (n >= 20)
		begin
			errors++;
			$display("[ERR] wb ack expected 1 seen 0");
		end
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask

	task automatic sc(input logic ir, input int n, input logic [307:0] din,
		output logic [307:0] dout);
		bst_jtag_tester_inst.scan(ir, n, din, dout);
	endtask

	task automatic t_regs();
		logic [31:0] q;
		wb(1'b0, 4'h0, 4'hf, '0, q);
		chk("ctrl", 3'h7, q);
		chk("pull", 2'h3, pull_o);
		chk("user in off", 4'h0, user_jpin_o);
		wb(1'b0, 4'h4, 4'hf, '0, q);
		chk("status", {`BST_OP_IDCODE, 4'h0}, q);
		wb(1'b1, 4'h8, 4'hf, '0, q);
		wb(1'b0, 4'h8, 4'hf, '0, q);
		chk("id", `BST_IDCODE, q);
		wb(1'b1, 4'h0, 4'he, '0, q);
		wb(1'b0, 4'h0, 4'hf, '0, q);
		chk("ctrl sel", 3'h7, q);
		$display("regs done");
	endtask

	task automatic t_idcode();
		logic [307:0] d;
		logic         b;
		bst_jtag_tester_inst.tick(1'b0, 1'b0, b);
		sc(1'b0, 32, '0, d);
		chk("idcode", `BST_IDCODE, d[31:0]);
		chk("tdo oe idle", 1'b0, jpin_oe_o[3]);
		$display("idcode done");
	endtask

	task automatic t_bypass();
		logic [307:0] d;
		logic [3:0]   ops [2] = '{`BST_OP_BYPASS, 4'h5};
		foreach (ops[i])
		begin
			sc(1'b1, 4, ops[i], d);
			chk("ir capture", `BST_IR_CAPTURE, d[3:0]);
			sc(1'b0, 8, 8'hb5, d);
			chk("bypass", 8'h6a, d[7:0]);
		end
		$display("bypass done");
	endtask

	task automatic t_sample();
		logic [307:0] d, dd, e;
		logic [95:0]  po, pe;
		for (int i = 0; i < 308; i++)
			dd[i] = i[0] ^ i[3];
		@(posedge clk_i);
		io_pin_i     <= {24{4'h9}};
		core_io_i    <= {12{8'h3c}};
		core_io_oe_i <= {48{2'b10}};
		in_pin_i     <= 4'h6;
		mc_i         <= 16'ha5c3;
		sc(1'b1, 4, `BST_OP_SAMPLE, d);
		chk("core io", io_pin_i, core_io_o);
		chk("core in", in_pin_i, core_in_o);
		chk("pad out", core_io_i, io_pin_o);
		chk("pad oe", core_io_oe_i, io_pin_oe_o);
		sc(1'b0, 308, dd, d);
		for (int k = 0; k < 96; k++)
		begin
			e[3*k +: 3] = {io_pin_i[k], core_io_oe_i[k], core_io_i[k]};
			po[k] = dd[3*k];
			pe[k] = dd[3*k+1];
		end
		e[291:288] = in_pin_i;
		e[307:292] = mc_i;
		chk("sample", e, d);
		sc(1'b1, 4, `BST_OP_EXTEST, d);
		chk("extest out", po, io_pin_o);
		chk("extest oe", pe, io_pin_oe_o);
		chk("extest in", dd[291:288], core_in_o);
		bst_jtag_tester_inst.to_idle();
		$display("sample extest done");
	endtask

	task automatic t_prog();
		logic [307:0] d;
		sc(1'b1, 4, `BST_OP_PROG, d);
		stb_n = 0;
		sc(1'b0, 32, 32'h5a3c_0ff1, d);
		chk("prog word", 32'h5a3c_0ff1, prog_data_o);
		chk("prog strobes", 1, stb_n);
		sc(1'b0, 32, '0, d);
		chk("prog capture", 32'h5a3c_0ff1, d[31:0]);
		chk("prog clear", 0, prog_data_o);
		bst_jtag_tester_inst.to_idle();
		$display("prog done");
	endtask

	task automatic t_disable();
		logic [31:0] q;
		logic        b;
		wb(1'b1, 4'h0, 4'hf, '0, q);
		wb(1'b0, 4'h0, 4'hf, '0, q);
		chk("ctrl off", 0, q);
		@(posedge clk_i);
		user_jpin_i    <= 4'h5;
		user_jpin_oe_i <= 4'h8;
		repeat (5) bst_jtag_tester_inst.tick(1'b0, 1'b1, b);
		chk("pull off", 2'h0, pull_o);
		chk("user out", 4'h5, jpin_o);
		chk("user oe", 4'h8, jpin_oe_o);
		chk("user in", 4'h5, user_jpin_o);
		wb(1'b0, 4'h4, 4'hf, '0, q);
		chk("tap held", 4'h0, q[3:0]);
		wb(1'b1, 4'h0, 4'hf, 32'h3, q);
		wb(1'b0, 4'h0, 4'hf, '0, q);
		chk("ctrl tms", 3'h3, q);
		chk("pull tms", 2'h1, pull_o);
		wb(1'b1, 4'h0, 4'hf, 32'h7, q);
		$display("disable done");
	endtask

	initial
	begin
		{rst_i, flt, wb_cyc_i, wb_stb_i, wb_we_i} = 5'h10;
		{wb_adr_i, wb_sel_i, wb_dat_i, user_jpin_i, user_jpin_oe_i, in_pin_i} = '0;
		{io_pin_i, core_io_i, core_io_oe_i, mc_i} = '0;
		errors = 0;
		total_checks = 0;
		stb_n = 0;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		t_regs();
		t_idcode();
		t_bypass();
		t_sample();
		t_prog();
		t_disable();
		tally_and_finish();
	end

	// the whole run needs well under half a millisecond
	initial
	begin
		#2000000;
		errors++;
		$display("[ERR] watchdog expected done seen timeout");
		tally_and_finish();
	end
endmodule // bst_test_port_tb
`default_nettype wire
